/* include/ca_pkg.sv */
package ca_pkg;

  localparam int CA_NMOD = 5;
  localparam int CA_WDT_MOD = 4;

  // register byte offsets
  localparam logic [7:0] CA_OFS_MODE = 8'h00;
  localparam logic [7:0] CA_OFS_CTRL = 8'h04;
  localparam logic [7:0] CA_OFS_COUNT = 8'h08;
  localparam logic [7:0] CA_OFS_MOD_BASE = 8'h10;
  localparam logic [7:0] CA_OFS_MOD_STRIDE = 8'h10;
  localparam logic [7:0] CA_SUB_MMODE = 8'h00;
  localparam logic [7:0] CA_SUB_CMP_LO = 8'h04;
  localparam logic [7:0] CA_SUB_CMP_HI = 8'h08;

  // counter_array_mode fields
  localparam int CA_MODE_IDLE_STOP = 7;
  localparam int CA_MODE_WDT_EN = 6;
  localparam int CA_MODE_SRC_HI = 2;
  localparam int CA_MODE_SRC_LO = 1;
  localparam int CA_MODE_OVF_IRQ_EN = 0;
  localparam logic [7:0] CA_MODE_MASK = 8'hC7;

  // counter_array_control_flags fields
  localparam int CA_CTRL_OVF = 7;
  localparam int CA_CTRL_RUN = 6;

  // module_mode_select fields
  localparam int CA_MM_IRQ_EN = 0;
  localparam int CA_MM_PWM = 1;
  localparam int CA_MM_TOGGLE = 2;
  localparam int CA_MM_FLAG_MATCH = 3;
  localparam int CA_MM_CAP_FALL = 4;
  localparam int CA_MM_CAP_RISE = 5;
  localparam int CA_MM_CMP_EN = 6;
  localparam logic [7:0] CA_MM_MASK = 8'h7F;

  // count source codes
  localparam logic [1:0] CA_SRC_OSC_SLOW = 2'h0;
  localparam logic [1:0] CA_SRC_OSC_FAST = 2'h1;
  localparam logic [1:0] CA_SRC_TIMER0 = 2'h2;
  localparam logic [1:0] CA_SRC_EXT = 2'h3;

  // last prescaler count per divisor (divisor minus one)
  localparam logic [3:0] CA_DIV6_LAST = 4'h5;
  localparam logic [3:0] CA_DIV2_LAST = 4'h1;
  localparam logic [3:0] CA_DIV12_LAST = 4'hB;
  localparam logic [3:0] CA_DIV4_LAST = 4'h3;

  // reset values
  localparam logic [7:0] CA_RST_MODE = 8'h00;
  localparam logic [7:0] CA_RST_MMODE = 8'h00;
  localparam logic [15:0] CA_RST_CMP = 16'h0000;
  localparam logic [15:0] CA_RST_CNT = 16'h0000;
  localparam logic CA_RST_PIN = 1'b1;

  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } ca_avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } ca_avs_rsp_t;

  typedef struct packed {
    logic [7:0] mode;
    logic run;
    logic ovf;
    logic [CA_NMOD-1:0] flag;
    logic [15:0] cnt;
    logic [3:0] div;
    logic [CA_NMOD-1:0][7:0] mmode;
    logic [CA_NMOD-1:0][15:0] cmp;
    logic [CA_NMOD-1:0] pin_out;
    logic [CA_NMOD-1:0] pin_oe_n;
    logic eci_s1;
    logic eci_s2;
    logic eci_prev;
    logic [CA_NMOD-1:0] pin_s1;
    logic [CA_NMOD-1:0] pin_s2;
    logic [CA_NMOD-1:0] pin_prev;
    logic irq;
    logic wdt;
    ca_avs_rsp_t rsp;
  } ca_state_t;

endpackage

/* rtl/ca_counter_array.sv */
// How it works
// (R01) one 16-bit time base shared by five modules, each with its own 16-bit value
// (R02) each module does capture, software timer, toggle output or PWM
// (R03) module n owns port 1 pin 3+n as capture input or compare output
// (R04) source code 00 osc/6, 01 osc/2, 10 timer 0 overflow, 11 external pin
// (R05) in twelve-clock mode the oscillator sources divide by twelve and four
// (R06) external count pin advances the time base on each detected transition
// (R07) idle stop bit halts the time base during idle; clear keeps it counting
// (R08) watchdog enable bit switches the watchdog function on module 4
// (R09) time base counts only while run control bit 6 is set
// (R10) overflow sets flag bit 7 and requests interrupt when its enable is set
// (R11) overflow flag is cleared only by software writing zero
// (R12) flag bits 0..4 set by module match or capture, cleared only by software
// (R13) mode bit 0 lets the module flag raise an interrupt
// (R14) mode bit 1 enables PWM for the module
// (R15) mode bit 2 toggles the module pin when time base equals module value
// (R16) mode bit 3 sets the module flag on a match
// (R17) mode bit 4 captures on falling edges, bit 5 on rising, both on either
// (R18) mode bit 6 enables the module comparator
// (R19) capture copies the time base into the module value; compare holds match value
// (R20) in PWM the module value sets the output duty cycle
// (R21) time base adds one per count pulse, wraps to zero, overflow on wrap
// (R22) interrupt is OR of enabled overflow flag and enabled module flags
// (R23) external count and module pins pass a two-flop synchroniser first
//
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
module ca_counter_array (
  input wire logic clk_sys_i,                     // system clock, 100 MHz
  input wire logic nrst_i,                        // async reset, active low
  input wire ca_pkg::ca_avs_req_t avs_req_i,      // avalon request
  output ca_pkg::ca_avs_rsp_t avs_rsp_o,          // avalon response
  input wire logic cpu_idle_i,                    // processor in idle mode
  input wire logic clk12_mode_i,                  // twelve-clock machine cycle mode
  input wire logic timer0_ovf_i,                  // timer 0 overflow pulse
  input wire logic external_count_input_i,        // external count pin, async
  input wire logic [4:0] module_io_pin_i,         // module pins, async
  output logic [4:0] module_io_pin_o,             // module pin drive value
  output logic [4:0] module_io_pin_oe_n_o,        // low while driving pin
  output logic irq_o,                             // combined interrupt request
  output logic watchdog_reset_o                   // watchdog match pulse
);
  import ca_pkg::*;

  ca_state_t st_reg;
  ca_state_t st_next;

  logic run_ok;
  logic [1:0] src;
  logic [3:0] div_last;
  logic div_wrap;
  logic eci_edge;
  logic tick;
  logic ovf_ev;
  logic [15:0] cnt_inc;
  logic [CA_NMOD-1:0] rise;
  logic [CA_NMOD-1:0] fall;
  logic [CA_NMOD-1:0] cap_ev;
  logic [CA_NMOD-1:0] match;
  logic [CA_NMOD-1:0] irq_en;
  logic bus_req;
  logic bus_ack;

  function automatic logic ca_mod_hit(input logic [7:0] addr, input int n,
                                      input logic [7:0] sub);
    logic [7:0] base;
    base = CA_OFS_MOD_BASE + 8'(n) * CA_OFS_MOD_STRIDE;
    return addr == base + sub;
  endfunction

  // (R07) idle stop
  // (R09) run gating
  assign run_ok = st_reg.run && !(st_reg.mode[CA_MODE_IDLE_STOP] && cpu_idle_i);
  assign src = {st_reg.mode[CA_MODE_SRC_HI], st_reg.mode[CA_MODE_SRC_LO]};
  // (R05) twelve clock divisors
  assign div_last = clk12_mode_i ?
                    ((src == CA_SRC_OSC_SLOW) ? CA_DIV12_LAST : CA_DIV4_LAST) :
                    ((src == CA_SRC_OSC_SLOW) ? CA_DIV6_LAST : CA_DIV2_LAST);
  assign div_wrap = st_reg.div >= div_last;
  // (R06) any external transition
  assign eci_edge = st_reg.eci_s2 != st_reg.eci_prev;
  // (R04) count source select
  always_comb begin
    if (!run_ok) begin
      tick = 1'b0;
    end else if (src == CA_SRC_TIMER0) begin
      tick = timer0_ovf_i;
    end else if (src == CA_SRC_EXT) begin
      tick = eci_edge;
    end else begin
      tick = div_wrap;
    end
  end
  // (R21) increment and wrap
  assign cnt_inc = st_reg.cnt + 16'h0001;
  assign ovf_ev = tick && (st_reg.cnt == 16'hFFFF);

  assign rise = st_reg.pin_s2 & ~st_reg.pin_prev;
  assign fall = ~st_reg.pin_s2 & st_reg.pin_prev;

  genvar g;
  generate
    for (g = 0; g < CA_NMOD; g++) begin : g_mod
      // (R17) edge select
      assign cap_ev[g] = (st_reg.mmode[g][CA_MM_CAP_FALL] && fall[g]) ||
                         (st_reg.mmode[g][CA_MM_CAP_RISE] && rise[g]);
      // (R18) comparator enable
      assign match[g] = st_reg.mmode[g][CA_MM_CMP_EN] && tick &&
                        (cnt_inc == st_reg.cmp[g]);
      assign irq_en[g] = st_reg.mmode[g][CA_MM_IRQ_EN];
    end
  endgenerate

  assign bus_req = avs_req_i.read || avs_req_i.write;
  assign bus_ack = bus_req && !st_reg.rsp.waitrequest;

  always_comb begin
    logic wr;
    logic [7:0] wd;
    logic [31:0] rd;
    logic irq_mod;
    st_next = st_reg;
    wr = avs_req_i.write && bus_ack;
    wd = avs_req_i.writedata[7:0];
    rd = 32'h0000_0000;
    irq_mod = 1'b0;

    // (R23) two-flop synchronisers
    st_next.eci_s1 = external_count_input_i;
    st_next.eci_s2 = st_reg.eci_s1;
    st_next.eci_prev = st_reg.eci_s2;
    st_next.pin_s1 = module_io_pin_i;
    st_next.pin_s2 = st_reg.pin_s1;
    st_next.pin_prev = st_reg.pin_s2;

    // prescaler restarts whenever it is not dividing the oscillator
    if (run_ok && !src[1]) begin
      st_next.div = div_wrap ? 4'h0 : st_reg.div + 4'h1;
    end else begin
      st_next.div = 4'h0;
    end
    // (R01) shared time base
    if (tick) begin
      st_next.cnt = cnt_inc;
    end

    // software writes first, hardware events below win over them
    if (wr) begin
      if (avs_req_i.address == CA_OFS_MODE) begin
        st_next.mode = wd & CA_MODE_MASK;
      end else if (avs_req_i.address == CA_OFS_CTRL) begin
        st_next.run = wd[CA_CTRL_RUN];
        // (R11) zero write clears
        st_next.ovf = st_reg.ovf && wd[CA_CTRL_OVF];
        // (R12) zero write clears
        st_next.flag = st_reg.flag & wd[CA_NMOD-1:0];
      end
      for (int n = 0; n < CA_NMOD; n++) begin
        if (ca_mod_hit(avs_req_i.address, n, CA_SUB_MMODE)) begin
          st_next.mmode[n] = wd & CA_MM_MASK;
        end else if (ca_mod_hit(avs_req_i.address, n, CA_SUB_CMP_LO)) begin
          st_next.cmp[n][7:0] = wd;
        end else if (ca_mod_hit(avs_req_i.address, n, CA_SUB_CMP_HI)) begin
          st_next.cmp[n][15:8] = wd;
        end
      end
    end

    // (R10) overflow sets flag
    if (ovf_ev) begin
      st_next.ovf = 1'b1;
    end

    for (int n = 0; n < CA_NMOD; n++) begin
      // (R19) capture copies time base
      if (cap_ev[n]) begin
        st_next.cmp[n] = st_reg.cnt;
      end
      // (R12) capture or match flag
      // (R16) flag on match
      if (cap_ev[n] || (match[n] && st_reg.mmode[n][CA_MM_FLAG_MATCH])) begin
        st_next.flag[n] = 1'b1;
      end
      // (R03) pin drive
      // (R02) pin driven only in output modes
      st_next.pin_oe_n[n] = !(st_reg.mmode[n][CA_MM_CMP_EN] &&
                              (st_reg.mmode[n][CA_MM_TOGGLE] ||
                               st_reg.mmode[n][CA_MM_PWM]));
      if (st_reg.mmode[n][CA_MM_PWM] && st_reg.mmode[n][CA_MM_CMP_EN]) begin
        // (R14) pwm mode
        // (R20) duty from low byte
        st_next.pin_out[n] = st_reg.cnt[7:0] >= st_reg.cmp[n][7:0];
      end else if (match[n] && st_reg.mmode[n][CA_MM_TOGGLE]) begin
        // (R15) toggle on match
        st_next.pin_out[n] = !st_reg.pin_out[n];
      end
    end

    // (R08) watchdog on module 4
    st_next.wdt = st_reg.mode[CA_MODE_WDT_EN] && match[CA_WDT_MOD];

    // (R22) combined interrupt
    // (R13) per module enable
    // next-cycle enables, so irq never lags a mode write by one cycle
    for (int n = 0; n < CA_NMOD; n++) begin
      irq_mod = irq_mod || (st_next.flag[n] && st_next.mmode[n][CA_MM_IRQ_EN]);
    end
    st_next.irq = (st_next.ovf && st_next.mode[CA_MODE_OVF_IRQ_EN]) || irq_mod;

    // read data is latched while waitrequest is high and shown in the ack cycle
    if (avs_req_i.address == CA_OFS_MODE) begin
      rd[7:0] = st_reg.mode;
    end else if (avs_req_i.address == CA_OFS_CTRL) begin
      rd[CA_CTRL_OVF] = st_reg.ovf;
      rd[CA_CTRL_RUN] = st_reg.run;
      rd[CA_NMOD-1:0] = st_reg.flag;
    end else if (avs_req_i.address == CA_OFS_COUNT) begin
      rd[15:0] = st_reg.cnt;
    end
    for (int n = 0; n < CA_NMOD; n++) begin
      if (ca_mod_hit(avs_req_i.address, n, CA_SUB_MMODE)) begin
        rd[7:0] = st_reg.mmode[n];
      end else if (ca_mod_hit(avs_req_i.address, n, CA_SUB_CMP_LO)) begin
        rd[7:0] = st_reg.cmp[n][7:0];
      end else if (ca_mod_hit(avs_req_i.address, n, CA_SUB_CMP_HI)) begin
        rd[7:0] = st_reg.cmp[n][15:8];
      end
    end
    if (bus_req && st_reg.rsp.waitrequest) begin
      st_next.rsp.readdata = rd;
    end
    // one wait cycle, then a single ack cycle
    st_next.rsp.waitrequest = !(bus_req && st_reg.rsp.waitrequest);
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
      st_reg.mode <= CA_RST_MODE;
      st_reg.cnt <= CA_RST_CNT;
      st_reg.mmode <= {CA_NMOD{CA_RST_MMODE}};
      st_reg.cmp <= {CA_NMOD{CA_RST_CMP}};
      st_reg.pin_out <= {CA_NMOD{CA_RST_PIN}};
      st_reg.pin_oe_n <= {CA_NMOD{1'b1}};
      // pins idle high on their pull-ups: no false edge after reset
      st_reg.pin_s1 <= {CA_NMOD{CA_RST_PIN}};
      st_reg.pin_s2 <= {CA_NMOD{CA_RST_PIN}};
      st_reg.pin_prev <= {CA_NMOD{CA_RST_PIN}};
      st_reg.rsp.waitrequest <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign avs_rsp_o = st_reg.rsp;
  assign module_io_pin_o = st_reg.pin_out;
  assign module_io_pin_oe_n_o = st_reg.pin_oe_n;
  assign irq_o = st_reg.irq;
  assign watchdog_reset_o = st_reg.wdt;

  AST_OVF_WRAP: assert property ( // (R10)
    @(posedge clk_sys_i) disable iff (!nrst_i)
    ovf_ev |=> (st_reg.ovf && st_reg.cnt == 16'h0000))
    else $error("overflow did not wrap and set flag");

  AST_RUN_STOP: assert property ( // (R09)
    @(posedge clk_sys_i) disable iff (!nrst_i)
    !st_reg.run |=> $stable(st_reg.cnt))
    else $error("time base moved while stopped");

  AST_IDLE_HOLD: assert property ( // (R07)
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (st_reg.mode[CA_MODE_IDLE_STOP] && cpu_idle_i) |=> $stable(st_reg.cnt))
    else $error("time base moved in idle with stop set");

  AST_OVF_STICKY: assert property ( // (R11)
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (st_reg.ovf && !(bus_ack && avs_req_i.write && avs_req_i.address == CA_OFS_CTRL))
    |=> st_reg.ovf)
    else $error("overflow flag cleared by hardware");

  AST_DIV6: assert property ( // (R04)
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (tick && src == CA_SRC_OSC_SLOW && !clk12_mode_i && st_reg.div == CA_DIV6_LAST)
    |=> (!tick || src != CA_SRC_OSC_SLOW || clk12_mode_i)[*5])
    else $error("slow oscillator source ticks too fast");

  AST_CAPTURE: assert property ( // (R19)
    @(posedge clk_sys_i) disable iff (!nrst_i)
    cap_ev[1] |=> (st_reg.cmp[1] == $past(st_reg.cnt) && st_reg.flag[1]))
    else $error("capture did not store time base");

  AST_TOGGLE: assert property ( // (R15)
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (match[3] && st_reg.mmode[3][CA_MM_TOGGLE] && !st_reg.mmode[3][CA_MM_PWM])
    |=> st_reg.pin_out[3] != $past(st_reg.pin_out[3]))
    else $error("pin did not toggle on match");

  AST_MATCH_FLAG: assert property ( // (R16)
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (match[4] && st_reg.mmode[4][CA_MM_FLAG_MATCH]) |=> st_reg.flag[4])
    else $error("match did not set module flag");

  AST_IRQ: assert property ( // (R22)
    @(posedge clk_sys_i) disable iff (!nrst_i)
    irq_o == ((st_reg.ovf && st_reg.mode[CA_MODE_OVF_IRQ_EN]) || |(st_reg.flag & irq_en)))
    else $error("interrupt does not follow enabled flags");

  AST_BUS_ACK: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (bus_req && st_reg.rsp.waitrequest) |=> !st_reg.rsp.waitrequest ##1 st_reg.rsp.waitrequest)
    else $error("bus ack not one cycle after request");

  AST_TIMER0_COUNT: assert property ( // (R04)
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (run_ok && src == CA_SRC_TIMER0 && timer0_ovf_i)
    |=> st_reg.cnt == $past(st_reg.cnt) + 16'h0001)
    else $error("timer 0 overflow did not advance time base");

  AST_EXT_COUNT: assert property ( // (R06)
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (run_ok && src == CA_SRC_EXT && eci_edge)
    |=> st_reg.cnt == $past(st_reg.cnt) + 16'h0001)
    else $error("external transition did not advance time base");

  AST_DIV2: assert property ( // (R04)
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (tick && src == CA_SRC_OSC_FAST && !clk12_mode_i)
    |=> (!tick || src != CA_SRC_OSC_FAST || clk12_mode_i))
    else $error("fast oscillator source ticks too fast");

  AST_DIV4: assert property ( // (R05)
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (tick && src == CA_SRC_OSC_FAST && clk12_mode_i)
    |=> (!tick || src != CA_SRC_OSC_FAST || !clk12_mode_i)[*3])
    else $error("fast source in twelve-clock mode ticks too fast");

  AST_DIV12: assert property ( // (R05)
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (tick && src == CA_SRC_OSC_SLOW && clk12_mode_i)
    |=> (!tick || src != CA_SRC_OSC_SLOW || !clk12_mode_i)[*8])
    else $error("slow source in twelve-clock mode ticks too fast");

  AST_CAP_FALL: assert property ( // (R17)
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (st_reg.mmode[2][CA_MM_CAP_FALL] && fall[2])
    |=> (st_reg.flag[2] && st_reg.cmp[2] == $past(st_reg.cnt)))
    else $error("falling edge capture missed");

  AST_PWM_DUTY: assert property ( // (R20)
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (st_reg.mmode[0][CA_MM_PWM] && st_reg.mmode[0][CA_MM_CMP_EN])
    |=> st_reg.pin_out[0] == ($past(st_reg.cnt[7:0]) >= $past(st_reg.cmp[0][7:0])))
    else $error("pwm output does not follow duty value");

  AST_PIN_DRIVE: assert property ( // (R03)
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (st_reg.mmode[3][CA_MM_CMP_EN] && st_reg.mmode[3][CA_MM_TOGGLE])
    |=> !module_io_pin_oe_n_o[3])
    else $error("module pin not driven in output mode");

  AST_NO_TOGGLE: assert property ( // (R15)
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (!match[3] && !(st_reg.mmode[3][CA_MM_PWM] && st_reg.mmode[3][CA_MM_CMP_EN]))
    |=> $stable(st_reg.pin_out[3]))
    else $error("module pin changed without a match");

  AST_WDT_PULSE: assert property ( // (R08)
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (st_reg.mode[CA_MODE_WDT_EN] && match[CA_WDT_MOD])
    |=> watchdog_reset_o)
    else $error("watchdog match gave no pulse");

  AST_WDT_OFF: assert property ( // (R08)
    @(posedge clk_sys_i) disable iff (!nrst_i)
    !st_reg.mode[CA_MODE_WDT_EN] |=> !watchdog_reset_o)
    else $error("watchdog pulse while disabled");

  AST_FLAG_STICKY: assert property ( // (R12)
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (st_reg.flag[1] && !(bus_ack && avs_req_i.write && avs_req_i.address == CA_OFS_CTRL))
    |=> st_reg.flag[1])
    else $error("module flag cleared by hardware");

  AST_MOD_IRQ: assert property ( // (R13)
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (st_reg.flag[1] && st_reg.mmode[1][CA_MM_IRQ_EN]) |-> irq_o)
    else $error("enabled module flag raised no interrupt");

  AST_OVF_IRQ: assert property ( // (R10)
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (st_reg.ovf && st_reg.mode[CA_MODE_OVF_IRQ_EN]) |-> irq_o)
    else $error("enabled overflow flag raised no interrupt");

endmodule

/* tb/ca_pin_model.sv */
module ca_pin_model (
  input wire logic clk_sys_i,                 // system clock
  input wire logic [4:0] drive_i,             // design drive value
  input wire logic [4:0] drive_oe_n_i,        // low while design drives
  output logic [4:0] pin_level_o,             // resolved pin level
  output logic external_count_input_o         // external count pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] src;
  initial begin
    src = 5'h1F;
    external_count_input_o = 1'b0;
  end
  // released pins follow the level that set_pin gives src, high from the start; a driving design wins
  assign pin_level_o = (drive_oe_n_i & src) | (~drive_oe_n_i & drive_i);
  task set_pin(input int n, input logic v);
    @(posedge clk_sys_i);
    src[n] <= v;
    repeat (6) @(posedge clk_sys_i);
  endtask
  task ext_edges(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      external_count_input_o <= ~external_count_input_o;
      repeat (3) @(posedge clk_sys_i);
    end
  endtask
endmodule

/* tb/ca_counter_array_tb.sv */
module ca_counter_array_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ca_pkg::*;
  logic clk_sys_i;
  logic nrst_i;
  ca_avs_req_t req;
  ca_avs_rsp_t rsp;
  logic idle;
  logic k12;
  logic t0;
  logic ext;
  logic irq;
  logic wdt;
  logic [4:0] pin_i;
  logic [4:0] pin_o;
  logic [4:0] oe_n;
  logic [15:0] r16;
  logic [15:0] c;
  int n_mismatch;
  int comparisons;
  int cyc;
  int t_take;
  int n_wdt;

  ca_counter_array i_ca_counter_array (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .avs_req_i(req), .avs_rsp_o(rsp), .cpu_idle_i(idle), .clk12_mode_i(k12),
    .timer0_ovf_i(t0), .external_count_input_i(ext), .module_io_pin_i(pin_i),
    .module_io_pin_o(pin_o), .module_io_pin_oe_n_o(oe_n), .irq_o(irq),
    .watchdog_reset_o(wdt));
  ca_pin_model i_ca_pin_model (.clk_sys_i(clk_sys_i), .drive_i(pin_o),
    .drive_oe_n_i(oe_n), .pin_level_o(pin_i), .external_count_input_o(ext));

  always #5 clk_sys_i = ~clk_sys_i;

  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (wdt === 1'b1)
      n_wdt <= n_wdt + 1;
    if (cyc == 80000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task give_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int t;
    @(posedge clk_sys_i);
    req.address <= a;
    req.read <= ~w;
    req.write <= w;
    req.writedata <= {24'h000000, d};
    t = 0;
    do begin
      @(posedge clk_sys_i);
      t++;
    end while (rsp.waitrequest !== 1'b0);
    // one wait state, then the ack edge
    chk(16'(t), 16'h0002);
    r16 = rsp.readdata[15:0];
    t_take = cyc;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 8'h00);
    chk(r16, e);
  endtask

  function logic [7:0] ma(input int n, input logic [7:0] s);
    return CA_OFS_MOD_BASE + CA_OFS_MOD_STRIDE * 8'(n) + s;
  endfunction

  task tick(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      t0 <= 1'b1;
      @(posedge clk_sys_i);
      t0 <= 1'b0;
    end
    repeat (4) @(posedge clk_sys_i);
  endtask

  task s_reset();
    chk(16'(pin_o), 16'h001F);
    chk(16'(oe_n), 16'h001F);
    chk(16'(irq), 16'h0000);
    rd(CA_OFS_MODE, 16'h0000);
    rd(CA_OFS_CTRL, 16'h0000);
    rd(CA_OFS_COUNT, 16'h0000);
    for (int n = 0; n < CA_NMOD; n++) begin
      rd(ma(n, CA_SUB_MMODE), 16'h0000);
      rd(ma(n, CA_SUB_CMP_LO), 16'h0000);
      rd(ma(n, CA_SUB_CMP_HI), 16'h0000);
    end
    wr(8'h0C, 8'hFF);
    rd(8'h0C, 16'h0000);
    wr(CA_OFS_MODE, 8'hFF);
    rd(CA_OFS_MODE, {8'h00, CA_MODE_MASK});
    wr(ma(4, CA_SUB_MMODE), 8'hFF);
    rd(ma(4, CA_SUB_MMODE), {8'h00, CA_MM_MASK});
    wr(ma(4, CA_SUB_MMODE), 8'h00);
    wr(CA_OFS_MODE, 8'h00);
  endtask

  task s_count();
    wr(CA_OFS_MODE, 8'h04);
    wr(CA_OFS_CTRL, 8'h40);
    rd(CA_OFS_CTRL, 16'h0040);
    tick(10);
    rd(CA_OFS_COUNT, 16'h000A);
    wr(CA_OFS_CTRL, 8'h00);
    tick(3);
    rd(CA_OFS_COUNT, 16'h000A);
    wr(CA_OFS_MODE, 8'h06);
    wr(CA_OFS_CTRL, 8'h40);
    i_ca_pin_model.ext_edges(6);
    rd(CA_OFS_COUNT, 16'h0010);
    wr(CA_OFS_MODE, 8'h84);
    idle <= 1'b1;
    tick(2);
    rd(CA_OFS_COUNT, 16'h0010);
    wr(CA_OFS_MODE, 8'h04);
    tick(2);
    rd(CA_OFS_COUNT, 16'h0012);
    idle <= 1'b0;
  endtask

  // oscillator sources: the prescaler phase allows one count either way
  task s_osc(input logic [7:0] m, input logic k, input int div);
    int t1;
    int d;
    int e;
    k12 <= k;
    wr(CA_OFS_MODE, m);
    bus(1'b0, CA_OFS_COUNT, 8'h00);
    c = r16;
    t1 = t_take;
    repeat (240) @(posedge clk_sys_i);
    bus(1'b0, CA_OFS_COUNT, 8'h00);
    d = int'(r16 - c);
    e = (t_take - t1) / div;
    chk(16'(d >= e - 1 && d <= e + 1), 16'h0001);
  endtask

  task s_ovf();
    wr(CA_OFS_MODE, 8'h05);
    bus(1'b0, CA_OFS_COUNT, 8'h00);
    c = r16;
    @(posedge clk_sys_i);
    t0 <= 1'b1;
    repeat (65536) @(posedge clk_sys_i);
    t0 <= 1'b0;
    rd(CA_OFS_COUNT, c);
    rd(CA_OFS_CTRL, 16'h00C0);
    chk(16'(irq), 16'h0001);
    wr(CA_OFS_CTRL, 8'hC0);
    rd(CA_OFS_CTRL, 16'h00C0);
    wr(CA_OFS_CTRL, 8'h00);
    rd(CA_OFS_CTRL, 16'h0000);
    chk(16'(irq), 16'h0000);
  endtask

  task s_cap();
    wr(ma(1, CA_SUB_MMODE), 8'h21);
    wr(ma(2, CA_SUB_MMODE), 8'h10);
    i_ca_pin_model.set_pin(1, 1'b0);
    rd(CA_OFS_CTRL, 16'h0000);
    i_ca_pin_model.set_pin(1, 1'b1);
    rd(CA_OFS_CTRL, 16'h0002);
    chk(16'(irq), 16'h0001);
    rd(ma(1, CA_SUB_CMP_LO), {8'h00, c[7:0]});
    rd(ma(1, CA_SUB_CMP_HI), {8'h00, c[15:8]});
    i_ca_pin_model.set_pin(2, 1'b0);
    rd(CA_OFS_CTRL, 16'h0006);
    wr(CA_OFS_CTRL, 8'h00);
    repeat (2) @(posedge clk_sys_i);
    chk(16'(irq), 16'h0000);
  endtask

  task s_match();
    int w0;
    wr(CA_OFS_MODE, 8'h44);
    for (int n = 3; n < 5; n++) begin
      wr(ma(n, CA_SUB_CMP_LO), 8'(c + 16'h0002));
      wr(ma(n, CA_SUB_CMP_HI), 8'((c + 16'h0002) >> 8));
    end
    wr(ma(3, CA_SUB_MMODE), 8'h4C);
    wr(ma(4, CA_SUB_MMODE), 8'h48);
    wr(CA_OFS_CTRL, 8'h40);
    w0 = n_wdt;
    tick(1);
    rd(CA_OFS_CTRL, 16'h0040);
    chk(16'(pin_o[3]), 16'h0001);
    tick(1);
    rd(CA_OFS_CTRL, 16'h0058);
    chk(16'(pin_o[3]), 16'h0000);
    chk(16'(oe_n[3]), 16'h0000);
    chk(16'(n_wdt - w0), 16'h0001);
    chk(16'(irq), 16'h0000);
    wr(CA_OFS_CTRL, 8'h00);
  endtask

  task s_pwm();
    bus(1'b0, CA_OFS_COUNT, 8'h00);
    c = r16;
    wr(ma(0, CA_SUB_CMP_LO), c[7:0]);
    wr(ma(0, CA_SUB_MMODE), 8'h42);
    repeat (3) @(posedge clk_sys_i);
    chk(16'(pin_o[0]), 16'h0001);
    chk(16'(oe_n[0]), 16'h0000);
    wr(ma(0, CA_SUB_CMP_LO), c[7:0] + 8'h01);
    repeat (3) @(posedge clk_sys_i);
    chk(16'(pin_o[0]), 16'(c[7:0] == 8'hFF));
  endtask

  initial begin
    clk_sys_i = 1'b0;
    nrst_i = 1'b0;
    req = '0;
    idle = 1'b0;
    k12 = 1'b0;
    t0 = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    cyc = 0;
    n_wdt = 0;
    repeat (3) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    s_reset();
    s_count();
    s_osc(8'h00, 1'b0, 6);
    s_osc(8'h02, 1'b0, 2);
    s_osc(8'h00, 1'b1, 12);
    s_osc(8'h02, 1'b1, 4);
    k12 <= 1'b0;
    s_ovf();
    s_cap();
    s_match();
    s_pwm();
    give_verdict();
  end
endmodule
